// *** design/dtm_defs.svh ***
`ifndef DTM_DEFS_SVH
`define DTM_DEFS_SVH

// Special-function address of the timer mode register
`define DTM_MODE_REG_ADDR 8'h89
`define DTM_MODE_REG_RESET 8'h00

// Field positions inside the timer mode register
`define DTM_T1_GATE_BIT 7
`define DTM_T1_SRC_BIT 6
`define DTM_T1_MODE_HI 5
`define DTM_T1_MODE_LO 4
`define DTM_T0_GATE_BIT 3
`define DTM_T0_SRC_BIT 2
`define DTM_T0_MODE_HI 1
`define DTM_T0_MODE_LO 0

// Counter geometry
`define DTM_CNT_RESET 16'h0000
`define DTM_LOW5_MAX 5'h1F
`define DTM_BYTE_MAX 8'hFF
`define DTM_WORD_MAX 16'hFFFF

// Synchroniser reset level: pins idle high
`define DTM_SYNC_RESET 1'b1

`endif

// *** design/dtm_pkg.sv ***
package dtm_pkg;

  // Operating mode encoding shared by both timers
  typedef enum logic [1:0] {
    DTM_MODE_13BIT = 2'b00,
    DTM_MODE_16BIT = 2'b01,
    DTM_MODE_8BIT_RELOAD = 2'b10,
    DTM_MODE_INACTIVE = 2'b11
  } dtm_mode_t;

  // Per-timer control fields taken from the mode register
  typedef struct packed {
    logic gate;
    logic source;
    dtm_mode_t mode;
  } dtm_timer_cfg_t;

  // Per-timer status carried out of the block
  typedef struct packed {
    logic [15:0] count;
    logic overflow;
  } dtm_timer_stat_t;

endpackage

// *** design/dtm_edge_sync.sv ***
`include "dtm_defs.svh"

module dtm_edge_sync (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic pin_in,
  output logic level_sync,
  output logic fall_pulse
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Two-flop synchroniser; only sync_q reads meta_q
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= `DTM_SYNC_RESET;
      sync_q <= `DTM_SYNC_RESET;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // History of the clean sample for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= `DTM_SYNC_RESET;
    end else begin
      prev_q <= sync_q;
    end
  end

  assign level_sync = sync_q;
  // One pulse per high-to-low transition
  assign fall_pulse = prev_q & ~sync_q;

endmodule

// *** design/dtm_timer_mode.sv ***
`include "dtm_defs.svh"

module dtm_timer_mode (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic timer0_run_bit,
  input wire logic timer1_run_bit,
  input wire logic irq0_polarity_bit,
  input wire logic irq1_polarity_bit,
  input wire logic timer0_clk_tick,
  input wire logic timer1_clk_tick,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic ext_irq0_input,
  input wire logic ext_irq1_input,
  output logic [15:0] timer0_count,
  output logic [15:0] timer1_count,
  output logic timer0_overflow,
  output logic timer1_overflow,
  output logic timer0_active,
  output logic timer1_active
);

  logic [7:0] timer_mode_reg_q;
  logic [7:0] sfr_rdata_q;
  logic [1:0] run_vec;
  logic [1:0] pol_vec;
  logic [1:0] tick_vec;
  logic [1:0] pin_vec;
  logic [1:0] irq_vec;
  logic [1:0] pin_fall;
  logic [1:0] irq_level;
  logic [1:0] active_vec;
  dtm_pkg::dtm_timer_stat_t stat_q [2];

  // Pull one timer's control fields out of the mode register
  function automatic dtm_pkg::dtm_timer_cfg_t cfg_of(input logic idx, input logic [7:0] r);
    dtm_pkg::dtm_timer_cfg_t c;
    if (idx) begin
      c.gate = r[`DTM_T1_GATE_BIT];
      c.source = r[`DTM_T1_SRC_BIT];
      c.mode = dtm_pkg::dtm_mode_t'(r[`DTM_T1_MODE_HI:`DTM_T1_MODE_LO]);
    end else begin
      c.gate = r[`DTM_T0_GATE_BIT];
      c.source = r[`DTM_T0_SRC_BIT];
      c.mode = dtm_pkg::dtm_mode_t'(r[`DTM_T0_MODE_HI:`DTM_T0_MODE_LO]);
    end
    return c;
  endfunction

  // Mode register write; address alone selects it, no page qualifier
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_mode_reg_q <= `DTM_MODE_REG_RESET;
    end else if (sfr_wr && sfr_addr == `DTM_MODE_REG_ADDR) begin
      timer_mode_reg_q <= sfr_wdata;
    end
  end

  // Registered read, one cycle after the strobe; other addresses read zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_q <= `DTM_MODE_REG_RESET;
    end else if (sfr_rd) begin
      sfr_rdata_q <= (sfr_addr == `DTM_MODE_REG_ADDR) ? timer_mode_reg_q : 8'h00;
    end
  end

  assign sfr_rdata = sfr_rdata_q;

  // Gather per-timer inputs into vectors for the generate loop
  assign run_vec = {timer1_run_bit, timer0_run_bit};
  assign pol_vec = {irq1_polarity_bit, irq0_polarity_bit};
  assign tick_vec = {timer1_clk_tick, timer0_clk_tick};
  assign pin_vec = {timer1_count_pin, timer0_count_pin};
  assign irq_vec = {ext_irq1_input, ext_irq0_input};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      dtm_pkg::dtm_timer_cfg_t cfg;
      logic gate_ok;
      logic step;
      logic [12:0] inc13;
      logic [15:0] cnt;

      // Count pin and gate input both cross into the core clock
      dtm_edge_sync u_pin_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(pin_vec[g]),
        .level_sync(),
        .fall_pulse(pin_fall[g])
      );
      dtm_edge_sync u_irq_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(irq_vec[g]),
        .level_sync(irq_level[g]),
        .fall_pulse()
      );

      assign cfg = cfg_of(1'(g), timer_mode_reg_q);
      // Gate: active level is the one named by the polarity bit
      assign gate_ok = ~cfg.gate | (irq_level[g] == pol_vec[g]);
      assign active_vec[g] = run_vec[g] & gate_ok;
      // Source select: prescaled tick or falling pin edge
      assign step = active_vec[g] & (cfg.source ? pin_fall[g] : tick_vec[g]);
      assign cnt = stat_q[g].count;
      assign inc13 = {cnt[15:8], cnt[4:0]} + 13'h0001;

      // Counting datapath per mode; overflow is a one-cycle pulse
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          stat_q[g].count <= `DTM_CNT_RESET;
          stat_q[g].overflow <= 1'b0;
        end else begin
          stat_q[g].overflow <= 1'b0;
          if (step) begin
            unique case (cfg.mode)
              dtm_pkg::DTM_MODE_13BIT: begin
                stat_q[g].count <= {inc13[12:5], cnt[7:5], inc13[4:0]};
                stat_q[g].overflow <= (cnt[15:8] == `DTM_BYTE_MAX) &&
                                      (cnt[4:0] == `DTM_LOW5_MAX);
              end
              dtm_pkg::DTM_MODE_16BIT: begin
                stat_q[g].count <= cnt + 16'h0001;
                stat_q[g].overflow <= (cnt == `DTM_WORD_MAX);
              end
              dtm_pkg::DTM_MODE_8BIT_RELOAD: begin
                // Low byte counts, reloads from high byte on wrap
                if (cnt[7:0] == `DTM_BYTE_MAX) begin
                  stat_q[g].count <= {cnt[15:8], cnt[15:8]};
                  stat_q[g].overflow <= 1'b1;
                end else begin
                  stat_q[g].count <= {cnt[15:8], cnt[7:0] + 8'h01};
                end
              end
              dtm_pkg::DTM_MODE_INACTIVE: begin
                if (g == 0) begin
                  // Timer 0 keeps a free 8-bit low-byte count here
                  stat_q[g].count <= {cnt[15:8], cnt[7:0] + 8'h01};
                  stat_q[g].overflow <= (cnt[7:0] == `DTM_BYTE_MAX);
                end else begin
                  stat_q[g].count <= cnt;
                end
              end
            endcase
          end
        end
      end
    end
  endgenerate

  assign timer0_count = stat_q[0].count;
  assign timer1_count = stat_q[1].count;
  assign timer0_overflow = stat_q[0].overflow;
  assign timer1_overflow = stat_q[1].overflow;
  assign timer0_active = active_vec[0];
  // Mode 3 never counts on timer 1, so it is never reported active
  assign timer1_active = active_vec[1] & (cfg_of(1'b1, timer_mode_reg_q).mode !=
                         dtm_pkg::DTM_MODE_INACTIVE);

endmodule

// *** verification/dtm_timer_mode_checker.sv ***
module dtm_timer_mode_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer0_run_bit,
  input wire logic timer1_run_bit,
  input wire logic [15:0] timer0_count,
  input wire logic [15:0] timer1_count,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer0_active,
  input wire logic timer1_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Register bus: decode, readback, data held between reads
  chk_unmapped_read: assert property (
    sfr_rd && sfr_addr != 8'h89 |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  chk_write_readback: assert property (
    sfr_wr && !sfr_rd && sfr_addr == 8'h89 ##1 sfr_rd && !sfr_wr && sfr_addr == 8'h89
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("readback differs from write");
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");

  // Run bits and counting cause
  chk_t0_stopped: assert property (!timer0_run_bit |-> !timer0_active)
    else $error("timer0 active while stopped");
  chk_t1_stopped: assert property (!timer1_run_bit |-> !timer1_active)
    else $error("timer1 active while stopped");
  chk_t0_cause: assert property ($changed(timer0_count) |-> $past(timer0_active))
    else $error("timer0 counted while inactive");
  chk_t1_cause: assert property ($changed(timer1_count) |-> $past(timer1_active))
    else $error("timer1 counted while inactive");
  // Low byte moves by one or wraps; a second step per event would show here
  chk_t0_one_step: assert property ($changed(timer0_count) && $stable(timer0_count[15:8])
    |-> timer0_count[7:0] == $past(timer0_count[7:0]) + 8'h01 || timer0_count[7:0] == 8'h00)
    else $error("timer0 low byte jumped");
  // A wrap pulse needs a counting step in the cycle before
  chk_t0_ovf_cause: assert property (timer0_overflow |-> $past(timer0_active))
    else $error("timer0 overflow while inactive");
  chk_t1_ovf_cause: assert property (timer1_overflow |-> $past(timer1_active))
    else $error("timer1 overflow while inactive");
endmodule

bind dtm_timer_mode dtm_timer_mode_checker dtm_timer_mode_checker_i (.*);

// *** verification/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = '0, reset_n = '0, sfr_wr = '0, sfr_rd = '0, tick = '0, pin = '1;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, cfg, d, a;
  logic [1:0] run = '0, irq = '0, pol = '0;
  logic timer0_overflow, timer1_overflow, timer0_active, timer1_active;
  logic [15:0] timer0_count, timer1_count;
  int n_errors = 0, num_checks = 0, n;
  int ovf0 = 0, ovf1 = 0, o0, o1;

  // Free-running core clock
  always #5 core_clk = ~core_clk;

  // One tick and one pin feed both timers, so their settings can differ per run
  dtm_timer_mode dtm_timer_mode_i (.*, .timer0_clk_tick(tick), .timer1_clk_tick(tick),
    .timer0_count_pin(pin), .timer1_count_pin(pin), .timer0_run_bit(run[0]),
    .timer1_run_bit(run[1]), .irq0_polarity_bit(pol[0]), .irq1_polarity_bit(pol[1]),
    .ext_irq0_input(irq[0]), .ext_irq1_input(irq[1]));

  task automatic cmp8(logic [7:0] g, logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp16(logic [15:0] g, logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Bus tasks start and end at a falling edge
  task automatic wr(logic [7:0] ad, logic [7:0] v);
    sfr_addr = ad;
    sfr_wdata = v;
    sfr_wr = '1;
    @(negedge core_clk);
    sfr_wr = '0;
  endtask

  // Idle cycle at the end keeps the strobe from being set twice at once
  task automatic rd(logic [7:0] ad, output logic [7:0] v);
    sfr_addr = ad;
    sfr_rd = '1;
    @(negedge core_clk);
    sfr_rd = '0;
    v = sfr_rdata;
    @(negedge core_clk);
  endtask

  // Overflow pulses tallied at the falling edge, where they stand settled; X counts too
  always @(negedge core_clk) begin
    if (timer0_overflow !== 1'b0) ovf0++;
    if (timer1_overflow !== 1'b0) ovf1++;
  end

  // Timer k may count: run bit, gate level, and timer 1 not in mode 3
  function automatic logic act(int k);
    logic [3:0] f;
    f = 4'(cfg >> (4 * k));
    return run[k] && !(f[3] && irq[k] != pol[k]) && !(k == 1 && f[1:0] == 2'h3);
  endfunction

  // Steps reaching timer k: one tick or two pin falls per event
  function automatic int steps(int k, int ev);
    logic [3:0] f;
    f = 4'(cfg >> (4 * k));
    if (!act(k)) return 0;
    return f[2] ? 2 * ev : ev;
  endfunction

  // Expected number of wraps for the width each mode counts over
  function automatic int wraps(int k, int ev);
    logic [3:0] f;
    int s;
    f = 4'(cfg >> (4 * k));
    s = steps(k, ev);
    case (f[1:0])
      2'h0: return s / 8192;
      2'h1: return s / 65536;
      default: return s / 256;
    endcase
  endfunction

  // Expected count from mode, source, gate and number of events
  function automatic logic [15:0] model(int k, int ev);
    logic [3:0] f;
    int s;
    f = 4'(cfg >> (4 * k));
    s = steps(k, ev);
    case (f[1:0])
      2'h0: return {8'(s >> 5), 3'h0, 5'(s)};
      2'h1: return 16'(s);
      default: return {8'h00, 8'(s)};
    endcase
  endfunction

  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard, well past the longest possible run
  initial begin
    #500000;
    n_errors++;
    final_report;
  end

  // Each pass: reset, configure both timers, one tick and two pin falls per event
  initial begin
    void'($urandom(32'hFF9F7318));
    for (int i = 0; i < 20; i++) begin
      reset_n = '0;
      {run, irq, pol} = 6'($urandom);
      repeat (12) @(negedge core_clk);
      reset_n = '1;
      cfg = (8'($urandom) & 8'hCC) | 8'(((i / 4) % 4) << 4) | 8'(i % 4);
      a = 8'($urandom);
      if (a == 8'h89) a = 8'h88;
      rd(8'h89, d);
      cmp8(d, 8'h00);
      wr(8'h89, cfg);
      rd(8'h89, d);
      cmp8(d, cfg);
      wr(a, ~cfg);
      rd(a, d);
      cmp8(d, 8'h00);
      rd(8'h89, d);
      cmp8(d, cfg);
      n = $urandom_range(150, 1);
      o0 = ovf0;
      o1 = ovf1;
      repeat (n) begin
        tick = '1;
        pin = '0;
        @(negedge core_clk);
        tick = '0;
        pin = '1;
        @(negedge core_clk);
        pin = '0;
        @(negedge core_clk);
        pin = '1;
        @(negedge core_clk);
      end
      repeat (4) @(negedge core_clk);
      cmp16(timer0_count, model(0, n));
      cmp16(timer1_count, model(1, n));
      cmp16(16'(ovf0 - o0), 16'(wraps(0, n)));
      cmp16(16'(ovf1 - o1), 16'(wraps(1, n)));
      cmp8({6'h00, timer1_active, timer0_active}, {6'h00, act(1), act(0)});
    end
    final_report;
  end
endmodule
